// File: ram2p_pkg.sv
// shared constants for the composed two-port memory and the dual-port memory
package ram2p_pkg;
    // composed memory: 512 x 36 write side, 1024 x 18 read side
    localparam int WR_DEPTH = 512;
    localparam int WR_AW = 9;
    localparam int WR_DW = 36;
    localparam int RD_DEPTH = 1024;
    localparam int RD_AW = 10;
    localparam int RD_DW = 18;
    // each block holds one half of a write word
    localparam int HALF_W = 18;
    localparam int BANK_SEL_BIT = 0;
    // dual-port memory behind port a and the bus front end
    localparam int DP_DEPTH = 1024;
    localparam int DP_AW = 10;
    localparam int DP_DW = 18;
    // bus front end build-time choices
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    localparam int APB_WORD_LSB = 2;
    // latency from the request edge to data at the link
    localparam int RD_LAT = 1;
    localparam int DP_LAT = 2;
    localparam logic [RD_DW-1:0] RD_RESET = 18'h00000;
    localparam logic [DP_DW-1:0] DP_RESET = 18'h00000;

    // word address of a read-side address inside one block
    function automatic logic [WR_AW-1:0] bank_word(input logic [RD_AW-1:0] addr);
        return addr[RD_AW-1:1];
    endfunction

    // byte address of the bus to a memory word address
    function automatic logic [DP_AW-1:0] apb_word(input logic [APB_AW-1:0] addr);
        return addr[APB_WORD_LSB +: DP_AW];
    endfunction
endpackage

// File: ram2p_link.sv
// link between the memory end and the user logic that drives it
`timescale 1ns/1ns
interface ram2p_link;
    // composed two-port memory, write side
    logic write_en;
    logic [ram2p_pkg::WR_AW-1:0] write_address;
    logic [ram2p_pkg::WR_DW-1:0] write_data;
    // composed two-port memory, read side
    logic read_en;
    logic [ram2p_pkg::RD_AW-1:0] read_address;
    logic read_reg_load_en;
    logic read_reg_sync_clear_n;
    logic shared_async_clear_n;
    logic [ram2p_pkg::RD_DW-1:0] read_data;
    // dual-port memory, port a
    logic port_a_block_select;
    logic port_a_write_en;
    logic [ram2p_pkg::DP_AW-1:0] port_a_address;
    logic [ram2p_pkg::DP_DW-1:0] port_a_write_data;
    logic port_a_out_en;
    logic port_a_out_reg_sync_clear_n;
    logic port_a_out_reg_async_clear_n;
    logic [ram2p_pkg::DP_DW-1:0] port_a_read_data;

    modport mem (
        input write_en, write_address, write_data,
        input read_en, read_address, read_reg_load_en, read_reg_sync_clear_n,
        input shared_async_clear_n,
        input port_a_block_select, port_a_write_en, port_a_address, port_a_write_data,
        input port_a_out_en, port_a_out_reg_sync_clear_n, port_a_out_reg_async_clear_n,
        output read_data, port_a_read_data
    );
    modport user (
        output write_en, write_address, write_data,
        output read_en, read_address, read_reg_load_en, read_reg_sync_clear_n,
        output shared_async_clear_n,
        output port_a_block_select, port_a_write_en, port_a_address, port_a_write_data,
        output port_a_out_en, port_a_out_reg_sync_clear_n, port_a_out_reg_async_clear_n,
        input read_data, port_a_read_data
    );
endinterface

// File: ram2p_mem.sv
// memory end: composed 36-in/18-out two-port memory, dual-port memory, bus front end
`timescale 1ns/1ns
module ram2p_mem (
    input wire logic clk_sys,
    input wire logic rst,
    ram2p_link.mem link,
    input wire logic apb_psel,
    input wire logic apb_penable,
    input wire logic apb_pwrite,
    input wire logic [ram2p_pkg::APB_AW-1:0] apb_paddr,
    input wire logic [ram2p_pkg::APB_DW-1:0] apb_pwdata,
    output logic [ram2p_pkg::APB_DW-1:0] apb_prdata,
    output logic apb_pready,
    output logic apb_pslverr
);

    ////////////////////////////////////////////////////////////////////////////
    // composed two-port memory

    // two blocks, one per half of the write word; one block alone cannot
    // hand a 36-bit write back as 18-bit reads, hence the split
    logic [ram2p_pkg::HALF_W-1:0] bank_lo [0:ram2p_pkg::WR_DEPTH-1];
    logic [ram2p_pkg::HALF_W-1:0] bank_hi [0:ram2p_pkg::WR_DEPTH-1];
    logic [ram2p_pkg::RD_DW-1:0] read_data_r;
    logic [ram2p_pkg::RD_DW-1:0] read_data_nxt;
    logic [ram2p_pkg::WR_DW-1:0] store_word;
    logic [ram2p_pkg::WR_AW-1:0] read_word_addr;
    logic [ram2p_pkg::RD_DW-1:0] read_sel_word;
    logic shared_clear;
    logic read_load;

    // a write under the shared clear lands as zeros, standing in for garbage
    assign shared_clear = !link.shared_async_clear_n;
    assign store_word = shared_clear ? '0 : link.write_data;
    // block chosen by the read address lsb
    // the upper nine read address bits pick the word in both blocks alike
    assign read_word_addr = ram2p_pkg::bank_word(link.read_address);
    assign read_sel_word = link.read_address[ram2p_pkg::BANK_SEL_BIT] ?
                           bank_hi[read_word_addr] : bank_lo[read_word_addr];
    assign read_load = link.read_en && link.read_reg_load_en;

    // clear first, then sync clear, then load; otherwise hold last read
    always_comb begin
        read_data_nxt = read_data_r;
        if (shared_clear) begin
            read_data_nxt = ram2p_pkg::RD_RESET;
        end else if (!link.read_reg_sync_clear_n) begin
            read_data_nxt = ram2p_pkg::RD_RESET;
        end else if (read_load) begin
            read_data_nxt = read_sel_word;
        end
    end

    // write side: both halves at the same word address in one edge
    always_ff @(posedge clk_sys) begin
        if (link.write_en) begin
            bank_lo[link.write_address] <= store_word[ram2p_pkg::HALF_W-1:0];
            bank_hi[link.write_address] <= store_word[ram2p_pkg::WR_DW-1:ram2p_pkg::HALF_W];
        end
    end

    // read side: single stage, array straight to the link
    // a second stage would add latency the composed memory must not have
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            read_data_r <= ram2p_pkg::RD_RESET;
        end else begin
            read_data_r <= read_data_nxt;
        end
    end

    // one clock here, so write and read sides share it; neither assumes
    // anything about the other's timing beyond its own edge
    assign link.read_data = read_data_r;

    ////////////////////////////////////////////////////////////////////////////
    // dual-port memory: port a on the link, port b behind the bus

    logic [ram2p_pkg::DP_DW-1:0] dp_mem [0:ram2p_pkg::DP_DEPTH-1];
    logic [ram2p_pkg::DP_DW-1:0] a_stage_r;
    logic [ram2p_pkg::DP_DW-1:0] a_stage_nxt;
    logic [ram2p_pkg::DP_DW-1:0] a_dout_r;
    logic [ram2p_pkg::DP_DW-1:0] a_dout_nxt;
    logic a_write;
    logic a_read;
    logic port_b_block_select;
    logic b_write;
    logic [ram2p_pkg::DP_AW-1:0] b_address;
    logic [ram2p_pkg::DP_DW-1:0] b_write_data;

    // port a decode: block select gates both directions
    assign a_write = link.port_a_block_select && link.port_a_write_en;
    assign a_read = link.port_a_block_select && !link.port_a_write_en;

    // array stage: deselect drives zero, a simple write keeps the last read
    always_comb begin
        a_stage_nxt = a_stage_r;
        if (!link.port_a_block_select) begin
            a_stage_nxt = ram2p_pkg::DP_RESET;
        end else if (a_read) begin
            a_stage_nxt = dp_mem[link.port_a_address];
        end
    end

    // output register: async clear outranks sync clear, both outrank load
    always_comb begin
        a_dout_nxt = a_dout_r;
        if (!link.port_a_out_reg_async_clear_n) begin
            a_dout_nxt = ram2p_pkg::DP_RESET;
        end else if (!link.port_a_out_reg_sync_clear_n) begin
            a_dout_nxt = ram2p_pkg::DP_RESET;
        end else if (link.port_a_out_en) begin
            a_dout_nxt = a_stage_r;
        end
    end

    // writes from both ports; port a is written last so it wins a clash,
    // which is only a choice: same-address writes are not a legal use
    // and nothing here detects them; the user end drives port a only and never sees the bus
    always_ff @(posedge clk_sys) begin
        if (b_write) begin
            dp_mem[b_address] <= b_write_data;
        end
        if (a_write) begin
            dp_mem[link.port_a_address] <= link.port_a_write_data;
        end
    end

    // port a pipeline runs on the same clock as its array stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            a_stage_r <= ram2p_pkg::DP_RESET;
            a_dout_r <= ram2p_pkg::DP_RESET;
        end else begin
            a_stage_r <= a_stage_nxt;
            a_dout_r <= a_dout_nxt;
        end
    end

    assign link.port_a_read_data = a_dout_r;

    ////////////////////////////////////////////////////////////////////////////
    // bus front end on port b: one wait state per transfer

    logic pready_r;
    logic pready_nxt;
    logic [ram2p_pkg::APB_DW-1:0] prdata_r;
    logic [ram2p_pkg::APB_DW-1:0] prdata_nxt;
    logic pslverr_r;
    logic apb_access;

    // the memory op fires in the first access cycle only; pready in the
    // next cycle ends the transfer, so a held access cannot fire twice
    assign apb_access = apb_psel && apb_penable;
    assign port_b_block_select = apb_access && !pready_r;
    assign b_write = port_b_block_select && apb_pwrite;
    assign b_address = ram2p_pkg::apb_word(apb_paddr);
    assign b_write_data = apb_pwdata[ram2p_pkg::DP_DW-1:0];
    assign pready_nxt = port_b_block_select;

    // read data sits in the low bits, upper bits read as zero
    // prdata holds over writes, so it only ever shows the last read
    always_comb begin
        prdata_nxt = prdata_r;
        if (port_b_block_select && !apb_pwrite) begin
            prdata_nxt = {{(ram2p_pkg::APB_DW-ram2p_pkg::DP_DW){1'b0}}, dp_mem[b_address]};
        end
    end

    // all front-end state on the rising edge, cleared by reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready_r <= 1'b0;
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= pready_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= 1'b0;
        end
    end

    // every byte address maps onto a word, so there is no error to report;
    // pslverr is a flop held low so that every output leaves a register
    assign apb_pready = pready_r;
    assign apb_prdata = prdata_r;
    assign apb_pslverr = pslverr_r;

endmodule // ram2p_mem

// File: ram2p_user.sv
// user end: registers requests onto the link and returns read data
`timescale 1ns/1ns
module ram2p_user (
    input wire logic clk_sys,
    input wire logic rst,
    ram2p_link.user link,
    input wire logic wr_req,
    input wire logic [ram2p_pkg::WR_AW-1:0] wr_addr,
    input wire logic [ram2p_pkg::WR_DW-1:0] wr_data,
    input wire logic rd_req,
    input wire logic [ram2p_pkg::RD_AW-1:0] rd_addr,
    input wire logic clear_req,
    output logic [ram2p_pkg::RD_DW-1:0] rd_data,
    output logic rd_valid,
    input wire logic a_req,
    input wire logic a_write,
    input wire logic [ram2p_pkg::DP_AW-1:0] a_addr,
    input wire logic [ram2p_pkg::DP_DW-1:0] a_data,
    output logic [ram2p_pkg::DP_DW-1:0] a_rdata,
    output logic a_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // request registers: every link input is a flop or a tie-off, stable before the edge

    logic write_en_r;
    logic [ram2p_pkg::WR_AW-1:0] write_address_r;
    logic [ram2p_pkg::WR_DW-1:0] write_data_r;
    logic read_en_r;
    logic [ram2p_pkg::RD_AW-1:0] read_address_r;
    logic clear_n_r;
    logic a_sel_r;
    logic a_wen_r;
    logic [ram2p_pkg::DP_AW-1:0] a_addr_r;
    logic [ram2p_pkg::DP_DW-1:0] a_data_r;
    logic clear_ok;

    // a clear is held back while a write is going out, so no word is spoiled
    assign clear_ok = clear_req && !wr_req;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            write_en_r <= 1'b0;
            write_address_r <= '0;
            write_data_r <= '0;
            read_en_r <= 1'b0;
            read_address_r <= '0;
            clear_n_r <= 1'b1;
            a_sel_r <= 1'b0;
            a_wen_r <= 1'b0;
            a_addr_r <= '0;
            a_data_r <= '0;
        end else begin
            write_en_r <= wr_req;
            write_address_r <= wr_addr;
            write_data_r <= wr_data;
            read_en_r <= rd_req;
            read_address_r <= rd_addr;
            clear_n_r <= !clear_ok;
            a_sel_r <= a_req;
            a_wen_r <= a_req && a_write;
            a_addr_r <= a_addr;
            a_data_r <= a_data;
        end
    end

    assign link.write_en = write_en_r;
    assign link.write_address = write_address_r;
    assign link.write_data = write_data_r;
    assign link.read_en = read_en_r;
    assign link.read_address = read_address_r;
    assign link.read_reg_load_en = 1'b1;
    assign link.read_reg_sync_clear_n = 1'b1;
    assign link.shared_async_clear_n = clear_n_r;
    assign link.port_a_block_select = a_sel_r;
    assign link.port_a_write_en = a_wen_r;
    assign link.port_a_address = a_addr_r;
    assign link.port_a_write_data = a_data_r;
    assign link.port_a_out_en = 1'b1;
    assign link.port_a_out_reg_sync_clear_n = 1'b1;
    assign link.port_a_out_reg_async_clear_n = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // answer capture: read data is taken once its latency has passed

    logic rd_pend_r;
    logic rd_valid_r;
    logic [ram2p_pkg::RD_DW-1:0] rd_data_r;
    logic [ram2p_pkg::DP_LAT-1:0] a_pend_r;
    logic a_valid_r;
    logic [ram2p_pkg::DP_DW-1:0] a_rdata_r;

    // one stage in the memory for the composed read, two for port a
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_pend_r <= 1'b0;
            rd_valid_r <= 1'b0;
            rd_data_r <= '0;
            a_pend_r <= '0;
            a_valid_r <= 1'b0;
            a_rdata_r <= '0;
        end else begin
            rd_pend_r <= read_en_r;
            rd_valid_r <= rd_pend_r;
            rd_data_r <= rd_pend_r ? link.read_data : rd_data_r;
            a_pend_r <= {a_pend_r[ram2p_pkg::DP_LAT-2:0], a_sel_r && !a_wen_r};
            a_valid_r <= a_pend_r[ram2p_pkg::DP_LAT-1];
            a_rdata_r <= a_pend_r[ram2p_pkg::DP_LAT-1] ? link.port_a_read_data : a_rdata_r;
        end
    end

    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign a_rdata = a_rdata_r;
    assign a_valid = a_valid_r;

endmodule // ram2p_user

// File: ram2p_asserts.sv
// concurrent checks on the link between the user end and the memory end
`timescale 1ns/1ns
module ram2p_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic write_en,
    input wire logic [ram2p_pkg::WR_AW-1:0] write_address,
    input wire logic [ram2p_pkg::WR_DW-1:0] write_data,
    input wire logic read_en,
    input wire logic [ram2p_pkg::RD_AW-1:0] read_address,
    input wire logic read_reg_sync_clear_n,
    input wire logic shared_async_clear_n,
    input wire logic [ram2p_pkg::RD_DW-1:0] read_data,
    input wire logic port_a_block_select,
    input wire logic port_a_write_en,
    input wire logic [ram2p_pkg::DP_AW-1:0] port_a_address,
    input wire logic [ram2p_pkg::DP_DW-1:0] port_a_write_data,
    input wire logic port_a_out_en,
    input wire logic [ram2p_pkg::DP_DW-1:0] port_a_read_data
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    clear_zero_a: assert property (
        !shared_async_clear_n |=> read_data == '0)
        else $error("read data not zero after shared clear");
    read_hold_a: assert property (
        !read_en && shared_async_clear_n && read_reg_sync_clear_n |=> $stable(read_data))
        else $error("read data moved without a read");
    // read is one edge after the write edge, no pipeline stage between
    write_read_a: assert property (
        write_en && shared_async_clear_n ##1 read_en && !write_en && shared_async_clear_n
        && read_reg_sync_clear_n && read_address[9:1] == $past(write_address)
        |=> read_data == ($past(read_address[0]) ? $past(write_data[35:18], 2)
        : $past(write_data[17:0], 2)))
        else $error("composed read does not return the written half");
    clear_no_write_a: assert property (
        !(write_en && !shared_async_clear_n))
        else $error("write issued under shared clear");
    idle_after_reset_a: assert property (
        $fell(rst) |-> !write_en && !read_en && !port_a_block_select && shared_async_clear_n)
        else $error("link not idle after reset");
    deselect_zero_a: assert property (
        !port_a_block_select && port_a_out_en |-> ##2 port_a_read_data == '0)
        else $error("deselected port a not zero two edges later");
    a_write_read_a: assert property (
        port_a_block_select && port_a_write_en ##1 port_a_block_select && !port_a_write_en
        && port_a_address == $past(port_a_address)
        |-> ##2 port_a_read_data == $past(port_a_write_data, 3))
        else $error("port a read after write wrong");
    // simple write leaves the output path alone
    a_write_hold_a: assert property (
        port_a_block_select && port_a_write_en && port_a_out_en |-> ##2 $stable(port_a_read_data))
        else $error("port a write changed the output");
endmodule // ram2p_asserts

// File: asymmetric_two_port_ram_tb.sv
// self-checking bench: user end and memory end joined by the link
`timescale 1ns/1ns
module asymmetric_two_port_ram_tb;
    logic clk_sys = 1'b0, rst = 1'b1, wr_req = 1'b0, rd_req = 1'b0, clear_req = 1'b0;
    logic a_req = 1'b0, a_write = 1'b0, rd_valid, a_valid;
    logic apb_psel = 1'b0, apb_penable = 1'b0, apb_pwrite = 1'b0, apb_pready, apb_pslverr;
    logic [8:0] wr_addr = 9'h000;
    logic [35:0] wr_data = 36'h0;
    logic [9:0] rd_addr = 10'h000, a_addr = 10'h000;
    logic [17:0] a_data = 18'h00000, rd_data, a_rdata;
    logic [11:0] apb_paddr = 12'h000;
    logic [31:0] apb_pwdata = 32'h0, apb_prdata;
    int err_count = 0;
    int checked = 0;

    ram2p_link link ();
    ram2p_mem u_ram2p_mem (.clk_sys(clk_sys), .rst(rst), .link(link), .apb_psel(apb_psel),
        .apb_penable(apb_penable), .apb_pwrite(apb_pwrite), .apb_paddr(apb_paddr),
        .apb_pwdata(apb_pwdata), .apb_prdata(apb_prdata), .apb_pready(apb_pready),
        .apb_pslverr(apb_pslverr));
    ram2p_user u_ram2p_user (.clk_sys(clk_sys), .rst(rst), .link(link), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr),
        .clear_req(clear_req), .rd_data(rd_data), .rd_valid(rd_valid), .a_req(a_req),
        .a_write(a_write), .a_addr(a_addr), .a_data(a_data), .a_rdata(a_rdata),
        .a_valid(a_valid));
    ram2p_asserts u_ram2p_asserts (.clk_sys(clk_sys), .rst(rst), .write_en(link.write_en),
        .write_address(link.write_address), .write_data(link.write_data),
        .read_en(link.read_en), .read_address(link.read_address),
        .read_reg_sync_clear_n(link.read_reg_sync_clear_n),
        .shared_async_clear_n(link.shared_async_clear_n), .read_data(link.read_data),
        .port_a_block_select(link.port_a_block_select), .port_a_write_en(link.port_a_write_en),
        .port_a_address(link.port_a_address), .port_a_write_data(link.port_a_write_data),
        .port_a_out_en(link.port_a_out_en), .port_a_read_data(link.port_a_read_data));

    // free-running system clock
    always #25 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input string name, input logic [35:0] exp, input logic [35:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // bounded wait for a one-cycle valid pulse, sampled after the edge settles
    task automatic wait_valid(input logic port_a);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            #1;
            if ((port_a ? a_valid : rd_valid) === 1'b1) return;
        end
        err_count++;
        stop_test();
    endtask

    task automatic rd_half(input logic [9:0] addr, input logic [17:0] exp);
        @(posedge clk_sys);
        rd_req <= 1'b1;
        rd_addr <= addr;
        @(posedge clk_sys);
        rd_req <= 1'b0;
        wait_valid(1'b0);
        cmp("rd_data", 36'(exp), 36'(rd_data));
    endtask

    task automatic a_op(input logic wr, input logic [9:0] addr, input logic [17:0] d);
        @(posedge clk_sys);
        a_req <= 1'b1;
        a_write <= wr;
        a_addr <= addr;
        a_data <= d;
    endtask

    // request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
            input logic [31:0] exp);
        @(posedge clk_sys);
        apb_psel <= 1'b1;
        apb_pwrite <= wr;
        apb_paddr <= addr;
        apb_pwdata <= wd;
        @(posedge clk_sys);
        apb_penable <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            if (apb_pready === 1'b1) begin
                cmp("prdata", 36'(exp), 36'(apb_prdata));
                cmp("pslverr", 36'h0, 36'(apb_pslverr));
                apb_psel <= 1'b0;
                apb_penable <= 1'b0;
                @(posedge clk_sys);
                cmp("pready", 36'h0, 36'(apb_pready));
                return;
            end
        end
        err_count++;
        stop_test();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // back-to-back wide writes at both ends of the word range, then every half read
    task automatic t_composed;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            wr_req <= 1'b1;
            wr_addr <= 9'(i * 511);
            wr_data <= {18'h2AAAA ^ 18'(i), 18'h15555 + 18'(i)};
        end
        @(posedge clk_sys);
        wr_req <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            rd_half({9'(i * 511), 1'b0}, 18'h15555 + 18'(i));
            rd_half({9'(i * 511), 1'b1}, 18'h2AAAA ^ 18'(i));
        end
    endtask

    // read issued the cycle right after the write
    task automatic t_write_read;
        logic [35:0] d;
        d = 36'h9_8765_4321;
        @(posedge clk_sys);
        wr_req <= 1'b1;
        wr_addr <= 9'h0C3;
        wr_data <= d;
        @(posedge clk_sys);
        wr_req <= 1'b0;
        rd_req <= 1'b1;
        rd_addr <= {9'h0C3, 1'b1};
        @(posedge clk_sys);
        rd_req <= 1'b0;
        wait_valid(1'b0);
        cmp("rd_data", 36'(d[35:18]), 36'(rd_data));
    endtask

    // clear raised together with a write: the write must still land intact
    task automatic t_clear;
        logic [35:0] d;
        d = 36'hA_BCDE_F012;
        @(posedge clk_sys);
        clear_req <= 1'b1;
        wr_req <= 1'b1;
        wr_addr <= 9'h011;
        wr_data <= d;
        @(posedge clk_sys);
        wr_req <= 1'b0;
        repeat (3) @(posedge clk_sys);
        cmp("read_data", 36'h0, 36'(link.read_data));
        clear_req <= 1'b0;
        rd_half({9'h011, 1'b0}, d[17:0]);
    endtask

    // port a write then read, bus side sees it and writes back
    task automatic t_port_a;
        a_op(1'b1, 10'h3FF, 18'h1A5A5);
        a_op(1'b0, 10'h3FF, 18'h00000);
        @(posedge clk_sys);
        a_req <= 1'b0;
        wait_valid(1'b1);
        cmp("a_rdata", 36'h1A5A5, 36'(a_rdata));
        apb(1'b0, 12'hFFC, 32'h0, 32'h0001_A5A5);
        apb(1'b1, 12'h008, 32'hFFFF_0F0F, 32'h0001_A5A5);
        a_op(1'b0, 10'h002, 18'h00000);
        @(posedge clk_sys);
        a_req <= 1'b0;
        wait_valid(1'b1);
        cmp("a_rdata", 36'h30F0F, 36'(a_rdata));
    endtask

    // reset mid-run: registered outputs clear, stored words survive it
    task automatic t_reset;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        cmp("prdata", 36'h0, 36'(apb_prdata));
        cmp("pready", 36'h0, 36'(apb_pready));
        cmp("rd_data", 36'h0, 36'(rd_data));
        cmp("a_rdata", 36'h0, 36'(a_rdata));
        rd_half({9'h011, 1'b0}, 18'h2F012);
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_composed();
        t_write_read();
        t_clear();
        t_port_a();
        t_reset();
        repeat (4) @(posedge clk_sys);
        stop_test();
    end
endmodule // asymmetric_two_port_ram_tb
